// >>> pms_core_model.sv
// Behavioural model of the core-side interrupt sources and the crystal.
// Assumes the bench commands the sources on clk and the controller
// enables the crystal.
`timescale 1ns/100ps
`default_nettype none
module pms_core_model #(
   parameter int TICK_HALF = 4
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [3:0] src_cmd,
   input  wire logic       crystal_enable,
   output var  logic       irq_request,
   output var  logic       ext_irq_pin,
   output var  logic       power_fail_interrupt,
   output var  logic       power_fail_reset,
   output var  logic       xtal_tick_pin
);
   int unsigned ph;

   // ----------------------------------------------------------
   // Interrupt sources
   // ----------------------------------------------------------
   // Lines change just after an edge, as real source logic does
   always_ff @(posedge clk) begin
      irq_request          <= rst_b & src_cmd[0];
      ext_irq_pin          <= rst_b & src_cmd[1];
      power_fail_interrupt <= rst_b & src_cmd[2];
      power_fail_reset     <= rst_b & src_cmd[3];
   end

   // ----------------------------------------------------------
   // Crystal
   // ----------------------------------------------------------
   // Stands still while disabled; slow enough for the tick sampler
   always_ff @(posedge clk) begin
      if (!rst_b || !crystal_enable) begin
         ph            <= 0;
         xtal_tick_pin <= 1'b0;
      end else if (ph == TICK_HALF - 1) begin
         ph            <= 0;
         xtal_tick_pin <= ~xtal_tick_pin;
      end else begin
         ph <= ph + 1;
      end
   end
endmodule
`default_nettype wire

// >>> pms_ctrl.sv
// Power-mode controller: idle, stop, reference keep-alive, ring wake.
// Assumes a single 200 MHz clock, a plain register port, asynchronous
// wake pins and a crystal-clock tick pin from the oscillator block.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "pms_defs.svh"
module pms_ctrl
   import pms_pkg::*;
#(
   parameter int XTAL_CLOCKS = `PMS_XTAL_CLOCKS
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  logic [7:0] reg_rdata,
   input  wire logic       irq_request,
   input  wire logic       ext_irq_pin,
   input  wire logic       power_fail_interrupt,
   input  wire logic       power_fail_reset,
   input  wire logic       xtal_tick_pin,
   output var  logic       core_halt,
   output var  logic       clocks_gated,
   output var  logic       crystal_enable,
   output var  logic       ring_enable,
   output var  logic       core_clk_ring,
   output var  logic       reference_enable,
   output var  logic       reset_output_n,
   output var  logic       irq
);
   logic [3:0]            pin_sync;
   logic                  ext_wake;
   logic                  pf_int;
   logic                  pf_rst;
   logic                  xtal_tick;
   logic                  xtal_tick_d_reg;
   logic                  tick_edge;
   pms_mode_e             mode_reg;
   logic [7:0]            pwr_ctrl_reg;
   logic                  keep_alive_reg;
   logic                  ring_sel_reg;
   logic                  xtal_ready_reg;
   logic [`PMS_CNT_W-1:0] xcnt_reg;
   logic                  cnt_done;
   logic                  wr_pwr;
   logic                  stop_wake;
   logic [`PMS_EV_W-1:0]  ev_status_reg;
   logic [`PMS_EV_W-1:0]  ev_mask_reg;
   logic [`PMS_EV_W-1:0]  ev_set;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   pms_sync #(.W(4)) u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({xtal_tick_pin, power_fail_reset, power_fail_interrupt, ext_irq_pin}),
      .q     (pin_sync)
   );
   assign ext_wake  = pin_sync[0];
   assign pf_int    = pin_sync[1];
   assign pf_rst    = pin_sync[2];
   assign xtal_tick = pin_sync[3];

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         xtal_tick_d_reg <= 1'b0;
      end else begin
         xtal_tick_d_reg <= xtal_tick;
      end
   end
   assign tick_edge = xtal_tick & ~xtal_tick_d_reg;

   assign wr_pwr   = reg_wr && (reg_addr == `PMS_ADDR_PWR_CTRL);
   assign cnt_done = (xcnt_reg == `PMS_CNT_W'(XTAL_CLOCKS - 1)) && tick_edge;

   assign stop_wake = ext_wake || (keep_alive_reg && (pf_int || pf_rst));

   // -----------------------------------------------------------------
   // Mode sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mode_reg <= PMS_RUN;
      end else begin
         unique case (mode_reg)
            PMS_RUN: begin
               if (wr_pwr && reg_wdata[`PMS_BIT_STOP]) begin
                  mode_reg <= PMS_STOP;
               end else if (wr_pwr && reg_wdata[`PMS_BIT_IDLE]) begin
                  mode_reg <= PMS_IDLE;
               end
            end
            PMS_IDLE: begin
               if (irq_request || ext_wake) begin
                  mode_reg <= PMS_RUN;
               end
            end
            PMS_STOP: begin
               if (stop_wake) begin
                  // ring wake only on interrupt causes
                  mode_reg <= (ring_sel_reg && !pf_rst) ? PMS_RING_RUN : PMS_XTAL_UP;
               end
            end
            PMS_XTAL_UP: begin
               if (cnt_done) begin
                  mode_reg <= PMS_RUN;
               end
            end
            PMS_RING_RUN: begin
               if (cnt_done) begin
                  mode_reg <= PMS_RUN;
               // Re-entering stop from the ring abandons the hand-over
               end else if (wr_pwr && reg_wdata[`PMS_BIT_STOP]) begin
                  mode_reg <= PMS_STOP;
               end
            end
            default: mode_reg <= PMS_RUN;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Crystal clock counter
   // -----------------------------------------------------------------
   // synchronous count of crystal clocks
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         xcnt_reg <= '0;
      end else if (mode_reg == PMS_XTAL_UP || mode_reg == PMS_RING_RUN) begin
         if (tick_edge) begin
            xcnt_reg <= cnt_done ? '0 : xcnt_reg + 1'b1;
         end
      end else begin
         xcnt_reg <= '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         xtal_ready_reg <= 1'b1;
      end else if (cnt_done) begin
         xtal_ready_reg <= 1'b1;
      end else if (mode_reg == PMS_STOP) begin
         xtal_ready_reg <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Software registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pwr_ctrl_reg <= `PMS_RST_BYTE;
      end else if (wr_pwr) begin
         pwr_ctrl_reg <= reg_wdata;
         // Mode bits clear once the mode is run or crystal start-up, so the stop bit still reads set in ring run
         pwr_ctrl_reg[`PMS_BIT_IDLE] <= reg_wdata[`PMS_BIT_IDLE] && !reg_wdata[`PMS_BIT_STOP];
      end else if (mode_reg == PMS_RUN || mode_reg == PMS_XTAL_UP) begin
         pwr_ctrl_reg[`PMS_BIT_IDLE] <= 1'b0;
         pwr_ctrl_reg[`PMS_BIT_STOP] <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         keep_alive_reg <= 1'b0;
         ring_sel_reg   <= 1'b0;
      end else if (reg_wr && reg_addr == `PMS_ADDR_EXT_FLAGS) begin
         keep_alive_reg <= reg_wdata[`PMS_BIT_KEEP_ALIVE];
         ring_sel_reg   <= reg_wdata[`PMS_BIT_RING_SEL];
      end
   end

   // -----------------------------------------------------------------
   // Interrupt status and mask
   // -----------------------------------------------------------------
   assign ev_set[`PMS_EV_IDLE_EXIT]     = (mode_reg == PMS_IDLE) && (irq_request || ext_wake);
   assign ev_set[`PMS_EV_STOP_EXIT]     = (mode_reg == PMS_STOP) && stop_wake;
   assign ev_set[`PMS_EV_RING_HANDOVER] = (mode_reg == PMS_RING_RUN) && cnt_done;
   assign ev_set[`PMS_EV_XTAL_READY]    = (mode_reg == PMS_XTAL_UP) && cnt_done;

   // Set wins over a write-one clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ev_status_reg <= '0;
      end else if (reg_wr && reg_addr == `PMS_ADDR_IRQ_STATUS) begin
         ev_status_reg <= (ev_status_reg & ~reg_wdata[`PMS_EV_W-1:0]) | ev_set;
      end else begin
         ev_status_reg <= ev_status_reg | ev_set;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ev_mask_reg <= '0;
      end else if (reg_wr && reg_addr == `PMS_ADDR_IRQ_MASK) begin
         ev_mask_reg <= reg_wdata[`PMS_EV_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(ev_status_reg & ev_mask_reg);
      end
   end

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         reg_rdata <= `PMS_RST_BYTE;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `PMS_ADDR_PWR_CTRL:   reg_rdata <= pwr_ctrl_reg;
            `PMS_ADDR_EXT_FLAGS:  reg_rdata <= {5'h00, (mode_reg == PMS_RING_RUN),
                                               ring_sel_reg, keep_alive_reg};
            `PMS_ADDR_IRQ_STATUS: reg_rdata <= {4'h0, ev_status_reg};
            `PMS_ADDR_IRQ_MASK:   reg_rdata <= {4'h0, ev_mask_reg};
            `PMS_ADDR_STATUS:     reg_rdata <= 8'(xtal_ready_reg) << `PMS_BIT_XTAL_READY;
            default:              reg_rdata <= `PMS_RST_BYTE;
         endcase
      end else begin
         reg_rdata <= `PMS_RST_BYTE;
      end
   end

   // -----------------------------------------------------------------
   // Clock and analog controls
   // -----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         core_halt        <= 1'b0;
         clocks_gated     <= 1'b0;
         crystal_enable   <= 1'b1;
         ring_enable      <= 1'b0;
         core_clk_ring    <= 1'b0;
         reference_enable <= 1'b1;
         reset_output_n   <= 1'b1;
      end else begin
         core_halt        <= (mode_reg != PMS_RUN) && (mode_reg != PMS_RING_RUN);
         clocks_gated     <= (mode_reg == PMS_STOP) || (mode_reg == PMS_XTAL_UP);
         crystal_enable   <= (mode_reg != PMS_STOP);
         ring_enable      <= (mode_reg == PMS_RING_RUN);
         core_clk_ring    <= (mode_reg == PMS_RING_RUN);
         reference_enable <= (mode_reg != PMS_STOP) || keep_alive_reg;
         // reset output low in stop without reference
         reset_output_n   <= !((mode_reg == PMS_STOP) && !keep_alive_reg);
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_stop_pri;
      @(posedge clk) disable iff (!rst_b)
      (mode_reg == PMS_RUN && wr_pwr && reg_wdata[`PMS_BIT_STOP]) |=> mode_reg == PMS_STOP;
   endproperty
   a_stop_pri: assert property (p_stop_pri) else $error("stop not entered");
   property p_idle_exit;
      @(posedge clk) disable iff (!rst_b)
      (mode_reg == PMS_IDLE && irq_request) |=> mode_reg == PMS_RUN;
   endproperty
   a_idle_exit: assert property (p_idle_exit) else $error("idle not left");
   property p_stop_hold;
      @(posedge clk) disable iff (!rst_b)
      (mode_reg == PMS_STOP && !stop_wake) |=> mode_reg == PMS_STOP;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop left without cause");
   property p_rst_out;
      @(posedge clk) disable iff (!rst_b)
      (mode_reg == PMS_STOP && !keep_alive_reg) |=> !reset_output_n;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("reset output not low");
   property p_ref_on;
      @(posedge clk) disable iff (!rst_b)
      (mode_reg != PMS_STOP) |=> reference_enable;
   endproperty
   a_ref_on: assert property (p_ref_on) else $error("reference off outside stop");

   property p_ring_wake;
      @(posedge clk) disable iff (!rst_b)
      (mode_reg == PMS_STOP && ext_wake && ring_sel_reg && !pf_rst) |=> ##1 core_clk_ring;
   endproperty
   a_ring_wake: assert property (p_ring_wake) else $error("ring not used");
   property p_xtal_wake;
      @(posedge clk) disable iff (!rst_b)
      (mode_reg == PMS_STOP && stop_wake && !ring_sel_reg) |=> mode_reg == PMS_XTAL_UP;
   endproperty
   a_xtal_wake: assert property (p_xtal_wake) else $error("crystal not restarted");

   property p_cnt_bound;
      @(posedge clk) disable iff (!rst_b)
      xcnt_reg <= `PMS_CNT_W'(XTAL_CLOCKS - 1);
   endproperty
   a_cnt_bound: assert property (p_cnt_bound) else $error("count overrun");

   property p_handover;
      @(posedge clk) disable iff (!rst_b)
      (mode_reg == PMS_RING_RUN && cnt_done) |=> mode_reg == PMS_RUN ##1 !core_clk_ring;
   endproperty
   a_handover: assert property (p_handover) else $error("no hand-over");
endmodule
`default_nettype wire

// >>> pms_defs.svh
// Constants for the power-mode stop/wake controller.
// Assumes inclusion by the design modules and the bench.
`ifndef PMS_DEFS_SVH
`define PMS_DEFS_SVH

// -----------------------------------------------------------------
// Register addresses
// -----------------------------------------------------------------
`define PMS_ADDR_PWR_CTRL     8'h87
`define PMS_ADDR_EXT_FLAGS    8'h91
`define PMS_ADDR_IRQ_STATUS   8'hA0
`define PMS_ADDR_IRQ_MASK     8'hA1
`define PMS_ADDR_STATUS       8'hA2

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define PMS_BIT_IDLE          0
`define PMS_BIT_STOP          1
`define PMS_BIT_KEEP_ALIVE    0
`define PMS_BIT_RING_SEL      1
`define PMS_BIT_RING_ACT      2
`define PMS_BIT_XTAL_READY    4

// Interrupt status bits
`define PMS_EV_IDLE_EXIT      0
`define PMS_EV_STOP_EXIT      1
`define PMS_EV_RING_HANDOVER  2
`define PMS_EV_XTAL_READY     3
`define PMS_EV_W              4

// -----------------------------------------------------------------
// Reset values and counts
// -----------------------------------------------------------------
`define PMS_RST_BYTE          8'h00
`define PMS_RST_STATUS        8'h10
`define PMS_XTAL_CLOCKS       65536
`define PMS_CNT_W             17

`endif

// >>> pms_pkg.sv
// Types for the power-mode stop/wake controller.
// Assumes nothing of its surroundings.
`default_nettype none
package pms_pkg;
   typedef enum logic [2:0] {
      PMS_RUN      = 3'b000,
      PMS_IDLE     = 3'b001,
      PMS_STOP     = 3'b010,
      PMS_XTAL_UP  = 3'b011,
      PMS_RING_RUN = 3'b100
   } pms_mode_e;
endpackage
`default_nettype wire

// >>> pms_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module pms_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // -----------------------------------------------------------------
   // First flop feeds only the second
   // -----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// >>> power_mode_stop_wake_tb_top.sv
// Self-checking bench for the power-mode stop/wake controller.
// Assumes pms_ctrl and the core-side model pms_core_model.
`timescale 1ns/100ps
`default_nettype none
`include "pms_defs.svh"
module power_mode_stop_wake_tb_top import pms_pkg::*;;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [3:0] src_cmd = 4'h0;
   logic [7:0] reg_rdata;
   logic       irq_request;
   logic       ext_irq_pin;
   logic       power_fail_interrupt;
   logic       power_fail_reset;
   logic       xtal_tick_pin;
   logic       core_halt;
   logic       clocks_gated;
   logic       crystal_enable;
   logic       ring_enable;
   logic       core_clk_ring;
   logic       reference_enable;
   logic       reset_output_n;
   logic       irq;
   int         n_mismatch = 0;
   int         comparisons = 0;
   int         wcnt;

   always #2.5 clk = ~clk;

   // ----------------------------------------------------------
   // Instances
   // ----------------------------------------------------------
   // Short crystal count keeps each wake to a few dozen cycles
   pms_ctrl #(.XTAL_CLOCKS(8)) i_pms_ctrl (
      .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .irq_request(irq_request), .ext_irq_pin(ext_irq_pin),
      .power_fail_interrupt(power_fail_interrupt), .power_fail_reset(power_fail_reset),
      .xtal_tick_pin(xtal_tick_pin), .core_halt(core_halt), .clocks_gated(clocks_gated),
      .crystal_enable(crystal_enable), .ring_enable(ring_enable),
      .core_clk_ring(core_clk_ring), .reference_enable(reference_enable),
      .reset_output_n(reset_output_n), .irq(irq));
   pms_core_model i_pms_core_model (
      .clk(clk), .rst_b(rst_b), .src_cmd(src_cmd), .crystal_enable(crystal_enable),
      .irq_request(irq_request), .ext_irq_pin(ext_irq_pin),
      .power_fail_interrupt(power_fail_interrupt), .power_fail_reset(power_fail_reset),
      .xtal_tick_pin(xtal_tick_pin));

   // ----------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t %s is %b expected %b", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk_byte(reg_rdata, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic src(input logic [3:0] v);
      @(posedge clk);
      src_cmd <= v;
   endtask
   // Bounded wait on halt (0), ring clock (1) or crystal enable (2)
   task automatic wait_on(input int sel, input logic v);
      logic s;
      wcnt = 0;
      do begin
         cyc(1);
         wcnt++;
         s = (sel == 0) ? core_halt : (sel == 1) ? core_clk_ring : crystal_enable;
      end while (s !== v && wcnt < 300);
      chk_pin(s, v, "wait");
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------
   // Tests
   // ----------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      cyc(1);
      rd(`PMS_ADDR_PWR_CTRL, 8'h00);
      rd(`PMS_ADDR_EXT_FLAGS, 8'h00);
      rd(`PMS_ADDR_STATUS, 8'h10);
      wr(8'h55, 8'hFF);
      rd(8'h55, 8'h00);
      wr(`PMS_ADDR_EXT_FLAGS, 8'hFF);
      rd(`PMS_ADDR_EXT_FLAGS, 8'h03);
      wr(`PMS_ADDR_EXT_FLAGS, 8'h00);
      chk_pin(reset_output_n, 1'b1, "rst_out");
      $display("test reset done");
      wr(`PMS_ADDR_PWR_CTRL, 8'h01);
      cyc(2);
      chk_pin(core_halt, 1'b1, "halt");
      chk_pin(clocks_gated, 1'b0, "gated");
      chk_pin(reference_enable, 1'b1, "ref");
      src(4'h1);
      wait_on(0, 1'b0);
      src(4'h0);
      rd(`PMS_ADDR_IRQ_STATUS, 8'h01);
      chk_pin(irq, 1'b0, "irq");
      wr(`PMS_ADDR_IRQ_MASK, 8'h01);
      cyc(2);
      chk_pin(irq, 1'b1, "irq");
      wr(`PMS_ADDR_IRQ_STATUS, 8'h01);
      cyc(2);
      chk_pin(irq, 1'b0, "irq");
      rd(`PMS_ADDR_PWR_CTRL, 8'h00);
      $display("test idle done");
      wr(`PMS_ADDR_IRQ_MASK, 8'h02);
      wr(`PMS_ADDR_PWR_CTRL, 8'h03);
      cyc(3);
      chk_pin(clocks_gated, 1'b1, "gated");
      chk_pin(crystal_enable, 1'b0, "xtal");
      chk_pin(reference_enable, 1'b0, "ref");
      chk_pin(reset_output_n, 1'b0, "rst_out");
      rd(`PMS_ADDR_STATUS, 8'h00);
      src(4'h5);
      cyc(12);
      chk_pin(core_halt, 1'b1, "halt");
      src(4'h2);
      wait_on(2, 1'b1);
      chk_pin(core_halt, 1'b1, "halt");
      chk_pin(core_clk_ring, 1'b0, "ring");
      src(4'h0);
      wait_on(0, 1'b0);
      chk_pin(wcnt inside {[50:80]}, 1'b1, "span");
      chk_pin(irq, 1'b1, "irq");
      rd(`PMS_ADDR_STATUS, 8'h10);
      rd(`PMS_ADDR_PWR_CTRL, 8'h00);
      rd(`PMS_ADDR_IRQ_STATUS, 8'h0A);
      wr(`PMS_ADDR_IRQ_STATUS, 8'h0F);
      wr(`PMS_ADDR_IRQ_MASK, 8'h00);
      $display("test stop done");
      wr(`PMS_ADDR_EXT_FLAGS, 8'h03);
      wr(`PMS_ADDR_PWR_CTRL, 8'h02);
      cyc(3);
      chk_pin(reference_enable, 1'b1, "ref");
      chk_pin(reset_output_n, 1'b1, "rst_out");
      src(4'h2);
      wait_on(1, 1'b1);
      chk_pin(core_halt, 1'b0, "halt");
      chk_pin(ring_enable, 1'b1, "ring_on");
      src(4'h0);
      rd(`PMS_ADDR_EXT_FLAGS, 8'h07);
      // no timed traffic while the ring clocks the core
      // Back to stop from the ring: the hand-over is abandoned
      wr(`PMS_ADDR_PWR_CTRL, 8'h02);
      cyc(3);
      chk_pin(core_clk_ring, 1'b0, "ring");
      chk_pin(crystal_enable, 1'b0, "xtal");
      src(4'h2);
      wait_on(1, 1'b1);
      src(4'h0);
      wait_on(1, 1'b0);
      chk_pin(wcnt inside {[40:80]}, 1'b1, "span");
      chk_pin(core_halt, 1'b0, "halt");
      rd(`PMS_ADDR_EXT_FLAGS, 8'h03);
      rd(`PMS_ADDR_IRQ_STATUS, 8'h06);
      $display("test ring done");
      for (int s = 2; s < 4; s++) begin
         wr(`PMS_ADDR_EXT_FLAGS, (s == 2) ? 8'h01 : 8'h03);
         wr(`PMS_ADDR_PWR_CTRL, 8'h02);
         cyc(3);
         src(4'(1 << s));
         wait_on(0, 1'b0);
         chk_pin(core_clk_ring, 1'b0, "ring");
         src(4'h0);
      end
      $display("test power fail done");
      stop_test();
   end

   // Whole run is about four hundred cycles
   initial begin
      repeat (6000) @(posedge clk);
      n_mismatch++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      stop_test();
   end
endmodule
`default_nettype wire
